/* File: rtl/acs_top.sv */
// conversion sequencer core with register file and converter controls
// Contract
// R1: each conversion lasts exactly twelve bit periods from its start.
// R2: clock select codes give 2,4,8,16,32,64 periods or rc source.
// R3: rc selection times bit periods from dedicated oscillator, two to six us.
// R4: software picks a setting giving bit periods of at least 1.6 us.
// R5: sampling switch opens at conversion start, stays open throughout.
// R6: software waits out acquisition after a channel change before starting.
// R7: clearing start/busy during conversion aborts it at once.
// R8: abort leaves the result pair untouched.
// R9: after abort wait two bit periods, then acquire again; start accepted.
// R10: software never starts in the same write that powers on.
// R11: completion loads ten bits justified into sixteen, unused bits zero.
// R12: result bytes act as plain storage when no conversion writes them.
// R13: port reads return zero on analog-configured pins.
// R14: sequencing ignores channel and direction bits; output pins convert driven level.
// R15: digital-input pins on the selected channel still convert normally.
// R16: completion loads result, clears start/busy, sets done flag.
// R17: format set right justifies, clear left justifies, zero fill.
// R18: reset turns the converter off and aborts conversion.
// R19: setting start/busy while powered starts; hardware clears on completion.
// R20: bit timing comes from a prescaler restarted at each start; rc selection counts free-running oscillator edges.
`timescale 1ns/1ps
`default_nettype none
module acs_top
  import acs_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [7:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [7:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic RC_OSC_IN,
  input wire logic COMPARATOR_IN,
  input wire logic [7:0] PORT_PIN_IN,
  output logic [7:0] PORT_PIN_OUT,
  output logic [7:0] PORT_OE_B_OUT,
  output logic SAMPLE_SWITCH_OUT,
  output logic CONVERTER_POWER_OUT,
  output logic [2:0] CHANNEL_OUT,
  output logic [9:0] DAC_CODE_OUT
);
  acs_reg_if rif();
  acs_state_t state;
  acs_state_t next_state;
  logic converter_power_on;
  logic [2:0] conv_clock_select;
  logic [2:0] input_channel_select;
  logic result_format_select;
  logic conversion_done_flag;
  logic [7:0] result_high_byte;
  logic [7:0] result_low_byte;
  logic [7:0] analog_mask;
  logic [7:0] pin_direction_bits;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic tick;
  logic [3:0] tad_cnt;
  logic [9:0] sar;
  logic [3:0] bit_idx;
  logic [15:0] justified;
  logic [31:0] ctrl_wr;
  logic ctrl_we;
  logic start_req;
  logic abort_req;
  logic power_req;
  logic restart;
  logic conv_done;
  logic recov_done;
  logic [31:0] ctrl_rd;

  acs_axi_slave u_axi (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .rif(rif.bus),
    .awaddr_in(S_AXI_AWADDR_IN),
    .awvalid_in(S_AXI_AWVALID_IN),
    .awready_out(S_AXI_AWREADY_OUT),
    .wdata_in(S_AXI_WDATA_IN),
    .wstrb_in(S_AXI_WSTRB_IN),
    .wvalid_in(S_AXI_WVALID_IN),
    .wready_out(S_AXI_WREADY_OUT),
    .bresp_out(S_AXI_BRESP_OUT),
    .bvalid_out(S_AXI_BVALID_OUT),
    .bready_in(S_AXI_BREADY_IN),
    .araddr_in(S_AXI_ARADDR_IN),
    .arvalid_in(S_AXI_ARVALID_IN),
    .arready_out(S_AXI_ARREADY_OUT),
    .rdata_out(S_AXI_RDATA_OUT),
    .rresp_out(S_AXI_RRESP_OUT),
    .rvalid_out(S_AXI_RVALID_OUT),
    .rready_in(S_AXI_RREADY_IN)
  );

  acs_tick_gen u_tick (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .sel_in(conv_clock_select),
    .restart_in(restart),
    .rc_osc_in(RC_OSC_IN),
    .tick_out(tick)
  );

  // control write decode
  assign ctrl_we = rif.wr_en && rif.wr_addr == ACS_CTRL_OFS;
  assign ctrl_wr = (ctrl_rd & ~rif.wr_mask) | (rif.wr_data & rif.wr_mask);
  assign power_req = ctrl_wr[ACS_PWR_BIT];
  // start only on a write made while already powered
  assign start_req = ctrl_we && ctrl_wr[ACS_GO_BIT] && converter_power_on; // R19 R10
  assign abort_req = ctrl_we && !ctrl_wr[ACS_GO_BIT]; // R7
  assign conv_done = state == ACS_CONV && tick && tad_cnt == ACS_CONV_TADS - 4'h1; // R1
  assign recov_done = state == ACS_RECOV && tick && tad_cnt == ACS_ABORT_TADS - 4'h1; // R9
  assign restart = next_state != state && (next_state == ACS_CONV || next_state == ACS_RECOV);
  assign bit_idx = 4'ha - tad_cnt;

  always_comb
  begin
    next_state = state;
    case (state)
      ACS_OFF:
        if (ctrl_we && power_req)
          next_state = ACS_ACQ;
      ACS_ACQ:
        if (ctrl_we && !power_req)
          next_state = ACS_OFF;
        else if (start_req)
          next_state = ACS_CONV; // R19
      ACS_CONV:
        if (ctrl_we && !power_req)
          next_state = ACS_OFF;
        else if (abort_req)
          next_state = ACS_RECOV; // R7
        else if (conv_done)
          next_state = ACS_ACQ; // R16
      ACS_RECOV:
        if (ctrl_we && !power_req)
          next_state = ACS_OFF;
        else if (recov_done)
          next_state = ACS_ACQ; // R9
      default:
        next_state = ACS_OFF;
    endcase
  end

  // reset leaves the converter off R18
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      state <= ACS_OFF;
    else
      state <= next_state;
  end

  // switch open outside acquisition R5
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      SAMPLE_SWITCH_OUT <= 1'b0;
    else
      SAMPLE_SWITCH_OUT <= next_state == ACS_ACQ;
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      converter_power_on <= 1'b0;
      conv_clock_select <= ACS_SEL_D2;
      input_channel_select <= 3'h0;
      result_format_select <= 1'b0;
    end
    else if (ctrl_we)
    begin
      converter_power_on <= power_req;
      conv_clock_select <= ctrl_wr[ACS_CLKSEL_LSB +: 3];
      input_channel_select <= ctrl_wr[ACS_CHAN_LSB +: 3];
      result_format_select <= ctrl_wr[ACS_FMT_BIT];
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      CONVERTER_POWER_OUT <= 1'b0;
      CHANNEL_OUT <= 3'h0;
    end
    else
    begin
      CONVERTER_POWER_OUT <= next_state != ACS_OFF;
      CHANNEL_OUT <= ctrl_we ? ctrl_wr[ACS_CHAN_LSB +: 3] : input_channel_select;
    end
  end

  // bit period counter, restarted with the prescaler
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      tad_cnt <= 4'h0;
    else if (restart)
      tad_cnt <= 4'h0;
    else if (tick && (state == ACS_CONV || state == ACS_RECOV))
      tad_cnt <= tad_cnt + 4'h1; // R1
  end

  // approximation; channel and pin direction never gate it R14 R15
  // comparator is strobed on this clock, settled one clock after the trial code
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      sar <= ACS_SAR_FIRST;
    else if (restart)
      sar <= ACS_SAR_FIRST;
    else if (state == ACS_CONV && tick && tad_cnt >= 4'h1 && tad_cnt <= 4'ha)
    begin
      sar[bit_idx] <= COMPARATOR_IN;
      if (bit_idx != 4'h0)
        sar[bit_idx - 4'h1] <= 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      DAC_CODE_OUT <= 10'h0;
    else
      DAC_CODE_OUT <= sar;
  end

  // justification with zero fill R11 R17
  assign justified = result_format_select ? {6'h0, sar} : {sar, 6'h0};

  // result pair; aborts skip the load R8 R12
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      result_high_byte <= ACS_RES_RST;
      result_low_byte <= ACS_RES_RST;
    end
    else if (conv_done && next_state == ACS_ACQ)
    begin
      result_high_byte <= justified[15:8]; // R16
      result_low_byte <= justified[7:0];
    end
    else if (rif.wr_en && state != ACS_CONV)
    begin
      if (rif.wr_addr == ACS_RES_HI_OFS && rif.wr_mask[0])
        result_high_byte <= rif.wr_data[7:0]; // R12
      if (rif.wr_addr == ACS_RES_LO_OFS && rif.wr_mask[0])
        result_low_byte <= rif.wr_data[7:0];
    end
  end

  // done flag, write one clears, set wins
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      conversion_done_flag <= 1'b0;
    else if (next_state == ACS_ACQ && conv_done)
      conversion_done_flag <= 1'b1; // R16
    else if (rif.wr_en && rif.wr_addr == ACS_STAT_OFS && rif.wr_mask[0]
             && rif.wr_data[ACS_DONE_BIT])
      conversion_done_flag <= 1'b0;
  end

  // port pins and configuration
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      analog_mask <= ACS_ANA_RST;
      pin_direction_bits <= ACS_DIR_RST;
      PORT_PIN_OUT <= 8'h0;
    end
    else if (rif.wr_en && rif.wr_mask[0])
    begin
      if (rif.wr_addr == ACS_ANA_OFS)
        analog_mask <= rif.wr_data[7:0];
      if (rif.wr_addr == ACS_DIR_OFS)
        pin_direction_bits <= rif.wr_data[7:0];
      if (rif.wr_addr == ACS_PORT_OFS)
        PORT_PIN_OUT <= rif.wr_data[7:0];
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      PORT_OE_B_OUT <= ACS_DIR_RST;
    else
      PORT_OE_B_OUT <= pin_direction_bits;
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      pin_meta <= 8'h0;
      pin_sync <= 8'h0;
    end
    else
    begin
      pin_meta <= PORT_PIN_IN;
      pin_sync <= pin_meta;
    end
  end

  always_comb
  begin
    ctrl_rd = 32'h0;
    ctrl_rd[ACS_PWR_BIT] = converter_power_on;
    ctrl_rd[ACS_GO_BIT] = state == ACS_CONV; // R19
    ctrl_rd[ACS_CLKSEL_LSB +: 3] = conv_clock_select;
    ctrl_rd[ACS_CHAN_LSB +: 3] = input_channel_select;
    ctrl_rd[ACS_FMT_BIT] = result_format_select;
  end

  always_comb
  begin
    rif.rd_data = 32'h0;
    case (rif.rd_addr)
      ACS_CTRL_OFS: rif.rd_data = ctrl_rd;
      ACS_STAT_OFS:
      begin
        rif.rd_data[ACS_DONE_BIT] = conversion_done_flag;
        rif.rd_data[ACS_RECOV_BIT] = state == ACS_RECOV;
        rif.rd_data[ACS_ACQ_BIT] = state == ACS_ACQ;
      end
      ACS_RES_HI_OFS: rif.rd_data[7:0] = result_high_byte;
      ACS_RES_LO_OFS: rif.rd_data[7:0] = result_low_byte;
      ACS_ANA_OFS: rif.rd_data[7:0] = analog_mask;
      ACS_DIR_OFS: rif.rd_data[7:0] = pin_direction_bits;
      ACS_PORT_OFS: rif.rd_data[7:0] = pin_sync & ~analog_mask; // R13
      default: rif.rd_data = 32'h0;
    endcase
  end
endmodule
`default_nettype wire

/* File: rtl/acs_pkg.sv */
// constants for the conversion sequencer
package acs_pkg;
  localparam int ACS_AW = 8;
  localparam int ACS_NUM_REGS = 7;
  localparam logic [7:0] ACS_CTRL_OFS = 8'h00;
  localparam logic [7:0] ACS_STAT_OFS = 8'h04;
  localparam logic [7:0] ACS_RES_HI_OFS = 8'h08;
  localparam logic [7:0] ACS_RES_LO_OFS = 8'h0c;
  localparam logic [7:0] ACS_ANA_OFS = 8'h10;
  localparam logic [7:0] ACS_DIR_OFS = 8'h14;
  localparam logic [7:0] ACS_PORT_OFS = 8'h18;
  // control field positions
  localparam int ACS_PWR_BIT = 0;
  localparam int ACS_GO_BIT = 1;
  localparam int ACS_CLKSEL_LSB = 2;
  localparam int ACS_CHAN_LSB = 5;
  localparam int ACS_FMT_BIT = 8;
  // status field positions
  localparam int ACS_DONE_BIT = 0;
  localparam int ACS_RECOV_BIT = 1;
  localparam int ACS_ACQ_BIT = 2;
  // reset values
  localparam logic [7:0] ACS_ANA_RST = 8'hff;
  localparam logic [7:0] ACS_DIR_RST = 8'hff;
  localparam logic [7:0] ACS_RES_RST = 8'h00;
  // timing in bit periods
  localparam logic [3:0] ACS_CONV_TADS = 4'hc;
  localparam logic [3:0] ACS_ABORT_TADS = 4'h2;
  localparam logic [9:0] ACS_SAR_FIRST = 10'h200;
  localparam logic [1:0] ACS_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACS_RESP_DECERR = 2'h3;
  // clock select codes
  localparam logic [2:0] ACS_SEL_D2 = 3'h0;
  localparam logic [2:0] ACS_SEL_D4 = 3'h4;
  localparam logic [2:0] ACS_SEL_D8 = 3'h1;
  localparam logic [2:0] ACS_SEL_D16 = 3'h5;
  localparam logic [2:0] ACS_SEL_D32 = 3'h2;
  localparam logic [2:0] ACS_SEL_D64 = 3'h6;
  typedef enum logic [1:0] {
    ACS_OFF = 2'h0,
    ACS_ACQ = 2'h1,
    ACS_CONV = 2'h3,
    ACS_RECOV = 2'h2
  } acs_state_t;
endpackage

/* File: rtl/acs_reg_if.sv */
// register access carrier between bus slave and core
`timescale 1ns/1ps
`default_nettype none
interface acs_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] wr_mask;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  modport bus (output wr_en, wr_addr, wr_data, wr_mask, rd_en, rd_addr, input rd_data);
  modport core (input wr_en, wr_addr, wr_data, wr_mask, rd_en, rd_addr, output rd_data);
endinterface
`default_nettype wire

/* File: rtl/acs_tick_gen.sv */
// bit period tick from prescaler or rc oscillator pin
`timescale 1ns/1ps
`default_nettype none
module acs_tick_gen
  import acs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [2:0] sel_in,
  input wire logic restart_in,
  input wire logic rc_osc_in,
  output logic tick_out
);
  logic [6:0] div;
  logic [6:0] cnt;
  logic rc_meta;
  logic rc_sync;
  logic rc_prev;
  logic use_rc;

  always_comb
  begin
    use_rc = 1'b0;
    case (sel_in)
      ACS_SEL_D2: div = 7'h02;
      ACS_SEL_D4: div = 7'h04;
      ACS_SEL_D8: div = 7'h08;
      ACS_SEL_D16: div = 7'h10;
      ACS_SEL_D32: div = 7'h20;
      ACS_SEL_D64: div = 7'h40;
      default:
      begin
        div = 7'h02;
        use_rc = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rc_meta <= 1'b0;
      rc_sync <= 1'b0;
      rc_prev <= 1'b0;
    end
    else
    begin
      rc_meta <= rc_osc_in;
      rc_sync <= rc_meta;
      rc_prev <= rc_sync;
    end
  end

  // prescaler restarts at conversion start R20
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cnt <= 7'h00;
    else if (restart_in || cnt == div - 7'h01)
      cnt <= 7'h00;
    else
      cnt <= cnt + 7'h01;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      tick_out <= 1'b0;
    else if (restart_in)
      tick_out <= 1'b0;
    else if (use_rc)
      tick_out <= rc_sync && !rc_prev; // R3
    else
      tick_out <= cnt == div - 7'h01; // R2
  end
endmodule
`default_nettype wire

/* File: rtl/acs_axi_slave.sv */
// axi4-lite slave feeding the register carrier
`timescale 1ns/1ps
`default_nettype none
module acs_axi_slave
  import acs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  acs_reg_if.bus rif,
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in
);
  logic wr_hit;
  logic rd_hit;
  logic wr_go;
  logic rd_go;

  assign wr_hit = awaddr_in[7:2] < 6'(ACS_NUM_REGS);
  assign rd_hit = araddr_in[7:2] < 6'(ACS_NUM_REGS);
  assign wr_go = awready_out && awvalid_in && wvalid_in;
  assign rd_go = arready_out && arvalid_in;
  assign rif.wr_en = wr_go && wr_hit;
  assign rif.wr_addr = awaddr_in;
  assign rif.wr_data = wdata_in;
  assign rif.rd_en = rd_go;
  assign rif.rd_addr = araddr_in;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      rif.wr_mask[i*8 +: 8] = {8{wstrb_in[i]}};
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      awready_out <= 1'b0;
      wready_out <= 1'b0;
      bvalid_out <= 1'b0;
      bresp_out <= ACS_RESP_OKAY;
    end
    else if (wr_go)
    begin
      awready_out <= 1'b0;
      wready_out <= 1'b0;
      bvalid_out <= 1'b1;
      bresp_out <= wr_hit ? ACS_RESP_OKAY : ACS_RESP_DECERR;
    end
    else
    begin
      if (bvalid_out && bready_in)
        bvalid_out <= 1'b0;
      if (awvalid_in && wvalid_in && !bvalid_out && !awready_out)
      begin
        awready_out <= 1'b1;
        wready_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out <= 32'h0;
      rresp_out <= ACS_RESP_OKAY;
    end
    else if (rd_go)
    begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b1;
      rdata_out <= rd_hit ? rif.rd_data : 32'h0;
      rresp_out <= rd_hit ? ACS_RESP_OKAY : ACS_RESP_DECERR;
    end
    else
    begin
      if (rvalid_out && rready_in)
        rvalid_out <= 1'b0;
      if (arvalid_in && !rvalid_out && !arready_out)
        arready_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: sim/acs_analog_model.sv */
// analog hold capacitor and comparator model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model
(
  input wire logic clk_in,
  input wire logic switch_in,
  input wire logic [2:0] chan_in,
  input wire logic [9:0] dac_in,
  input wire logic [79:0] level_in,
  output logic cmp_out
);
  logic [9:0] held;
  // tracks the channel while the switch is closed, frozen once open
  always @(posedge clk_in)
  begin
    if (switch_in)
    begin
      held <= level_in[chan_in * 10 +: 10];
    end
  end
  assign cmp_out = (held >= dac_in);
endmodule
`default_nettype wire

/* File: sim/acs_top_assertions.sv */
// port-level checker for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_top_assertions
(
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic S_AXI_AWREADY_OUT,
  input wire logic S_AXI_WREADY_OUT,
  input wire logic [1:0] S_AXI_BRESP_OUT,
  input wire logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic S_AXI_ARREADY_OUT,
  input wire logic [31:0] S_AXI_RDATA_OUT,
  input wire logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic SAMPLE_SWITCH_OUT,
  input wire logic CONVERTER_POWER_OUT,
  input wire logic [7:0] PORT_OE_B_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  sequence s_wr_taken;
    S_AXI_AWREADY_OUT && S_AXI_WREADY_OUT;
  endsequence
  sequence s_conv_start;
    $fell(SAMPLE_SWITCH_OUT) && CONVERTER_POWER_OUT;
  endsequence
  property p_aw_w_pair;
    S_AXI_AWREADY_OUT == S_AXI_WREADY_OUT;
  endproperty
  a_aw_w_pair: assert property (p_aw_w_pair) else $error("write readies apart");
  property p_write_answer;
    s_wr_taken |=> S_AXI_BVALID_OUT && !S_AXI_AWREADY_OUT;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("no write response");
  property p_bvalid_cause;
    $rose(S_AXI_BVALID_OUT) |-> $past(S_AXI_AWREADY_OUT);
  endproperty
  a_bvalid_cause: assert property (p_bvalid_cause) else $error("response without write");
  property p_bvalid_hold;
    S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
  property p_read_answer;
    S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("no read data");
  property p_rvalid_hold;
    S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");
  property p_reset_off;
    $rose(RST_B_IN) |-> !CONVERTER_POWER_OUT && PORT_OE_B_OUT == 8'hff;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("not off after reset");
  property p_switch_open;
    s_conv_start |=> !SAMPLE_SWITCH_OUT [*3];
  endproperty
  a_switch_open: assert property (p_switch_open) else $error("switch closed early");
  property p_switch_powered;
    SAMPLE_SWITCH_OUT |-> CONVERTER_POWER_OUT;
  endproperty
  a_switch_powered: assert property (p_switch_powered) else $error("acquiring while off");
endmodule
`default_nettype wire

/* File: sim/acs_top_tb.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_top_tb
  import acs_pkg::*;
;
  logic clk = 0, rst_b = 0, rc = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0, pin = 0;
  logic [31:0] wdata = 0, rd;
  logic [79:0] lvl = 0;
  logic awready, wready, bvalid, arready, rvalid, sw, pwr, cmp;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  logic [7:0] pout, poe;
  logic [2:0] ch;
  logic [9:0] dac;
  int bad_count = 0, checked = 0;
  time t_fall = 0, t_rise = 0, t_wr = 0;
  acs_top dut (
    .CLK_IN(clk), .RST_B_IN(rst_b), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf),
    .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .RC_OSC_IN(rc), .COMPARATOR_IN(cmp), .PORT_PIN_IN(pin), .PORT_PIN_OUT(pout),
    .PORT_OE_B_OUT(poe), .SAMPLE_SWITCH_OUT(sw), .CONVERTER_POWER_OUT(pwr),
    .CHANNEL_OUT(ch), .DAC_CODE_OUT(dac)
  );
  acs_analog_model u_ana (.clk_in(clk), .switch_in(sw), .chan_in(ch), .dac_in(dac),
    .level_in(lvl), .cmp_out(cmp));
  always #2 clk = ~clk;
  always #1001 rc = ~rc;
  always @(negedge sw) t_fall = $time;
  always @(posedge sw) t_rise = $time;
  task automatic complete_run();
    $display("counts: %0d checked, %0d bad", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return awready;
      1: return bvalid;
      2: return arready;
      3: return rvalid;
      default: return sw;
    endcase
  endfunction
  task automatic wait_for(input int k, input int lim);
    int n;
    n = 0;
    #1;
    while (sig(k) !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= lim)
    begin
      bad_count++;
      $display("unexpected at %0t: wait ran out", $time);
      complete_run();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    wait_for(0, 20);
    @(posedge clk);
    t_wr = $time;
    awv <= 1'b0;
    wv <= 1'b0;
    wait_for(1, 20);
    @(posedge clk);
    bready <= 1'b1;
    @(posedge clk);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    wait_for(2, 20);
    @(posedge clk);
    arv <= 1'b0;
    wait_for(3, 20);
    @(posedge clk);
    rready <= 1'b1;
    @(posedge clk);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic t_reset();
    axi_rd(ACS_CTRL_OFS);
    check(rd, 32'h0);
    axi_rd(ACS_ANA_OFS);
    check(rd, {24'h0, ACS_ANA_RST});
    axi_rd(ACS_DIR_OFS);
    check(rd, {24'h0, ACS_DIR_RST});
    axi_rd(ACS_STAT_OFS);
    check(rd, 32'h0);
    axi_rd(8'h1c);
    check(resp, ACS_RESP_DECERR);
    axi_wr(ACS_CTRL_OFS, 32'h3);
    axi_rd(ACS_CTRL_OFS);
    check(rd[ACS_GO_BIT], 1'b0);
    axi_wr(ACS_CTRL_OFS, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_port();
    axi_wr(ACS_ANA_OFS, 32'h0f);
    axi_wr(ACS_DIR_OFS, 32'hf0);
    axi_wr(ACS_PORT_OFS, 32'h3c);
    check(resp, ACS_RESP_OKAY);
    pin <= 8'ha5;
    repeat (4) @(posedge clk);
    axi_rd(ACS_PORT_OFS);
    check(rd, 32'ha0);
    check(poe, 8'hf0);
    check(pout, 8'h3c);
    axi_wr(8'h1c, 32'h1);
    check(resp, ACS_RESP_DECERR);
    $display("t_port done");
  endtask
  task automatic t_convert(input logic [2:0] code, input logic fmt, input logic [9:0] v,
      input logic [2:0] c);
    logic [15:0] res;
    int p, tol, dur;
    p = (code[1:0] == 2'h3) ? 2002 : 4 * (2 << (2 * code[1:0] + code[2]));
    tol = (code[1:0] == 2'h3) ? p : 4;
    res = fmt ? {6'h0, v} : {v, 6'h0};
    lvl[c * 10 +: 10] <= v;
    axi_wr(ACS_CTRL_OFS, {23'h0, fmt, c, code, 2'b01});
    repeat (20) @(posedge clk);
    axi_wr(ACS_CTRL_OFS, {23'h0, fmt, c, code, 2'b11});
    wait_for(4, 8000);
    dur = int'(t_rise - t_fall) - 12 * p;
    check(dur <= tol && dur >= -tol, 1'b1);
    axi_rd(ACS_STAT_OFS);
    check(rd[ACS_DONE_BIT], 1'b1);
    axi_rd(ACS_CTRL_OFS);
    check(rd[ACS_GO_BIT], 1'b0);
    axi_rd(ACS_RES_HI_OFS);
    check(rd, {24'h0, res[15:8]});
    axi_rd(ACS_RES_LO_OFS);
    check(rd, {24'h0, res[7:0]});
    axi_wr(ACS_STAT_OFS, 32'h1);
    axi_rd(ACS_STAT_OFS);
    check(rd[ACS_DONE_BIT], 1'b0);
    $display("t_convert done");
  endtask
  task automatic t_abort();
    axi_wr(ACS_RES_HI_OFS, 32'h5a);
    axi_wr(ACS_RES_LO_OFS, 32'hc3);
    axi_rd(ACS_RES_HI_OFS);
    check(rd, 32'h5a);
    axi_wr(ACS_CTRL_OFS, 32'h15);
    repeat (20) @(posedge clk);
    axi_wr(ACS_CTRL_OFS, 32'h17);
    axi_rd(ACS_CTRL_OFS);
    check(rd[ACS_GO_BIT], 1'b1);
    axi_wr(ACS_CTRL_OFS, 32'h15);
    axi_rd(ACS_STAT_OFS);
    check(rd[ACS_RECOV_BIT], 1'b1);
    wait_for(4, 60);
    check(t_rise - t_wr >= 64 && t_rise - t_wr <= 136, 1'b1);
    axi_rd(ACS_RES_HI_OFS);
    check(rd, 32'h5a);
    axi_rd(ACS_RES_LO_OFS);
    check(rd, 32'hc3);
    axi_wr(ACS_CTRL_OFS, 32'h17);
    axi_rd(ACS_CTRL_OFS);
    check(rd[ACS_GO_BIT], 1'b1);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    check({pwr, sw}, 2'b00);
    rst_b <= 1'b1;
    axi_rd(ACS_CTRL_OFS);
    check(rd, 32'h0);
    $display("t_abort done");
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_port();
    for (int i = 0; i < 8; i++)
    begin
      t_convert(3'(i), 1'(i), 10'(137 * i + 5), 3'(7 - i));
    end
    t_convert(3'h0, 1'b1, 10'h3ff, 3'h0);
    t_convert(3'h4, 1'b0, 10'h000, 3'h1);
    t_abort();
    complete_run();
  end
endmodule
bind acs_top acs_top_assertions u_chk (.*);
`default_nettype wire
